// ===== core/fast_io_merge.sv
// Bit merge for plain, set, clear and toggle stores on one register.
// Assumes lane_mask already holds the byte lanes that the access reaches.
`timescale 1ns/1ps
`default_nettype none
module fast_io_merge (
    fast_io_merge_if.merger m
);
    import fast_io_pkg::*;
    wire [PORT_WIDTH-1:0] stored;
    wire [PORT_WIDTH-1:0] hit;
    wire [PORT_WIDTH-1:0] set_value;
    wire [PORT_WIDTH-1:0] clear_value;
    wire [PORT_WIDTH-1:0] toggle_value;

    assign stored = (m.wdata & m.lane_mask) | (m.current & ~m.lane_mask);
    // Ones outside the reached lanes must not act
    assign hit = m.wdata & m.lane_mask;
    assign set_value = m.current | hit;
    assign clear_value = m.current & ~hit;
    assign toggle_value = m.current ^ hit;
    assign m.result = (m.op == MERGE_SET) ? set_value :
                      (m.op == MERGE_CLEAR) ? clear_value :
                      (m.op == MERGE_TOGGLE) ? toggle_value : stored;
endmodule
`default_nettype wire

// ===== core/fast_io_merge_if.sv
// Carrier between the port top and its bit-merge unit.
// Assumes both ends sit on the same clock; the unit is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface fast_io_merge_if;
    import fast_io_pkg::*;
    merge_op_t op;
    logic [PORT_WIDTH-1:0] lane_mask;
    logic [PORT_WIDTH-1:0] wdata;
    logic [PORT_WIDTH-1:0] current;
    logic [PORT_WIDTH-1:0] result;
    modport requester (output op, output lane_mask, output wdata, output current,
                       input result);
    modport merger (input op, input lane_mask, input wdata, input current,
                    output result);
endinterface
`default_nettype wire

// ===== core/fast_io_pkg.sv
// Constants, field layouts and types of the fast local-bus I/O port.
// Assumes a 32-bit local bus with byte offsets inside the port's window.
package fast_io_pkg;
    localparam int unsigned PORT_WIDTH = 16;
    localparam int unsigned BUS_WIDTH = 32;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned LANE_WIDTH = 8;
    localparam int unsigned PORT_LANES = 2;

    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_SET = 8'h10;
    localparam logic [7:0] OFS_TOGGLE = 8'h14;

    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] UPPER_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_LONG = 2'b10,
        SIZE_NONE = 2'b11
    } access_size_t;

    typedef enum logic [1:0] {
        MERGE_STORE = 2'b00,
        MERGE_SET = 2'b01,
        MERGE_CLEAR = 2'b10,
        MERGE_TOGGLE = 2'b11
    } merge_op_t;
endpackage

// ===== core/local_bus_fast_gpio.sv
// Sixteen-bit fast I/O port, a slave on the core's 32-bit local bus.
// Assumes pads arrive asynchronously and fixed_function_in comes from clk_in logic.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sixteen I/O bits served as a slave directly on the 32-bit local bus.
// - Byte, word and longword reads and writes are all accepted.
// - Every access completes in one data phase cycle, never a wait state.
// - Output data reached directly and through set, clear and toggle addresses.
// - One plain store to an alternate address updates bits, no read-modify-write.
// - Direction and pin enable are registers of their own, apart from data.
// - Pins whose function the mode fixes lose the general-purpose function from the next clock edge on.
module local_bus_fast_gpio #(
    parameter int unsigned WIDTH = fast_io_pkg::PORT_WIDTH
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic bus_sel_in,
    input wire logic bus_write_in,
    input wire logic [fast_io_pkg::ADDR_WIDTH-1:0] bus_addr_in,
    input wire fast_io_pkg::access_size_t bus_size_in,
    input wire logic [fast_io_pkg::BUS_WIDTH-1:0] bus_wdata_in,
    output logic [fast_io_pkg::BUS_WIDTH-1:0] bus_rdata_out,
    output logic bus_ack_out,
    input wire logic [WIDTH-1:0] pad_in,
    input wire logic [WIDTH-1:0] fixed_function_in,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe_out,
    output logic [WIDTH-1:0] pad_select_out
);
    import fast_io_pkg::*;

    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] data;
    logic [WIDTH-1:0] enable;
    logic [WIDTH-1:0] pad_meta;
    logic [WIDTH-1:0] pad_sync;
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] select;
    logic [BUS_WIDTH-1:0] rdata;
    logic ack;

    fast_io_merge_if mif ();

    fast_io_merge u_merge (
        .m(mif.merger)
    );

    // Address decode
    wire [WIDTH-1:0] wdata_low;
    wire hit_dir;
    wire hit_data;
    wire hit_enable;
    wire hit_clear;
    wire hit_set;
    wire hit_toggle;
    wire hit_port;
    wire do_write;
    wire do_read;
    assign wdata_low = bus_wdata_in[WIDTH-1:0];
    assign hit_dir = bus_addr_in[7:2] == OFS_DIR[7:2];
    assign hit_data = bus_addr_in[7:2] == OFS_DATA[7:2];
    assign hit_enable = bus_addr_in[7:2] == OFS_ENABLE[7:2];
    assign hit_clear = bus_addr_in[7:2] == OFS_CLEAR[7:2];
    assign hit_set = bus_addr_in[7:2] == OFS_SET[7:2];
    assign hit_toggle = bus_addr_in[7:2] == OFS_TOGGLE[7:2];
    assign hit_port = hit_data | hit_clear | hit_set | hit_toggle;
    assign do_write = bus_sel_in & bus_write_in;
    assign do_read = bus_sel_in & ~bus_write_in;

    // Byte lanes reached; the port lives in lanes 0 and 1
    wire [PORT_LANES-1:0] lane_en;
    wire [WIDTH-1:0] lane_mask;
    assign lane_en[0] = (bus_size_in == SIZE_LONG) |
                        ((bus_size_in == SIZE_WORD) & ~bus_addr_in[1]) |
                        ((bus_size_in == SIZE_BYTE) & (bus_addr_in[1:0] == 2'b00));
    assign lane_en[1] = (bus_size_in == SIZE_LONG) |
                        ((bus_size_in == SIZE_WORD) & ~bus_addr_in[1]) |
                        ((bus_size_in == SIZE_BYTE) & (bus_addr_in[1:0] == 2'b01));
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            assign lane_mask[g] = lane_en[g / LANE_WIDTH];
        end
    endgenerate

    // One register is written per cycle, so one merge unit serves all three
    assign mif.op = hit_set ? MERGE_SET :
                    hit_clear ? MERGE_CLEAR :
                    hit_toggle ? MERGE_TOGGLE : MERGE_STORE;
    assign mif.lane_mask = lane_mask;
    assign mif.wdata = wdata_low;
    assign mif.current = hit_dir ? dir : (hit_enable ? enable : data);

    wire [WIDTH-1:0] next_dir;
    wire [WIDTH-1:0] next_data;
    wire [WIDTH-1:0] next_enable;
    assign next_dir = (do_write & hit_dir) ? mif.result : dir;
    assign next_data = (do_write & hit_port) ? mif.result : data;
    // Fixed-function pins drop out of the enable every cycle, not only on writes
    assign next_enable = ((do_write & hit_enable) ? mif.result : enable) &
                         ~fixed_function_in;

    // Inputs read the pad, outputs read back the driven value
    wire [WIDTH-1:0] pin_value;
    wire [BUS_WIDTH-1:0] read_value;
    assign pin_value = (dir & data) | (~dir & pad_sync);
    assign read_value = hit_dir ? {UPPER_ZERO, dir} :
                        hit_enable ? {UPPER_ZERO, enable} :
                        hit_port ? {UPPER_ZERO, pin_value} : {BUS_WIDTH{1'b0}};

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pad_meta <= {WIDTH{1'b0}};
            pad_sync <= {WIDTH{1'b0}};
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dir <= DIR_RESET;
            data <= DATA_RESET;
            enable <= ENABLE_RESET;
        end else begin
            dir <= next_dir;
            data <= next_data;
            enable <= next_enable;
        end
    end

    // Pad controls registered so the pins never see decode glitches
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe <= {WIDTH{1'b0}};
            select <= {WIDTH{1'b0}};
        end else begin
            oe <= next_dir & next_enable;
            select <= next_enable;
        end
    end

    // Answer always in the next cycle: zero wait states
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack <= 1'b0;
            rdata <= {BUS_WIDTH{1'b0}};
        end else begin
            ack <= bus_sel_in;
            rdata <= do_read ? read_value : {BUS_WIDTH{1'b0}};
        end
    end

    assign bus_ack_out = ack;
    assign bus_rdata_out = rdata;
    assign pad_out = data;
    assign pad_oe_out = oe;
    assign pad_select_out = select;

    wire long_write;
    assign long_write = do_write & (bus_size_in == SIZE_LONG);

    single_cycle_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        bus_sel_in |=> bus_ack_out)
        else $error("access not answered in the next cycle");

    no_stray_ack_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !bus_sel_in |=> !bus_ack_out)
        else $error("answer without an access");

    direct_store_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (long_write && hit_data) |=> (data == $past(wdata_low)))
        else $error("direct store did not land");

    set_bits_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (long_write && hit_set) |=> (data == ($past(data) | $past(wdata_low))))
        else $error("set store wrong");

    clear_bits_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (long_write && hit_clear) |=> (data == ($past(data) & ~$past(wdata_low))))
        else $error("clear store wrong");

    toggle_bits_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (long_write && hit_toggle) |=> (data == ($past(data) ^ $past(wdata_low))))
        else $error("toggle store wrong");

    byte_lane_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (do_write && hit_data && bus_size_in == SIZE_BYTE && bus_addr_in[1:0] == 2'b01)
        |=> (data[7:0] == $past(data[7:0])) && (data[15:8] == $past(wdata_low[15:8])))
        else $error("byte store touched the wrong lane");

    fixed_pin_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        1'b1 |=> ((enable & $past(fixed_function_in)) == {WIDTH{1'b0}}) &&
                 ((pad_select_out & $past(fixed_function_in)) == {WIDTH{1'b0}}))
        else $error("fixed-function pin taken as general purpose");

    drive_enable_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        pad_oe_out == (dir & enable))
        else $error("pad drive not from direction and enable");

    dir_readback_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (do_read && hit_dir) |=> (bus_rdata_out == {UPPER_ZERO, $past(dir)}))
        else $error("direction read back wrong");

    no_lane_write_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (do_write && bus_size_in == SIZE_NONE) |=> (data == $past(data)) && (dir == $past(dir)) &&
            (enable == ($past(enable) & ~$past(fixed_function_in))))
        else $error("write without lanes changed a register");
endmodule
`default_nettype wire

// ===== test/fast_io_core_model.sv
// Behavioural local-bus master standing in for the processor core.
// Assumes callers enter its tasks just after a rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module fast_io_core_model (
    input wire logic clk_in,
    output logic sel_out,
    output logic write_out,
    output logic [7:0] addr_out,
    output var fast_io_pkg::access_size_t size_out,
    output logic [31:0] wdata_out,
    input wire logic [31:0] rdata_in,
    input wire logic ack_in
);
    import fast_io_pkg::*;

    initial begin
        sel_out = 1'b0;
        write_out = 1'b0;
        addr_out = 8'h00;
        size_out = SIZE_NONE;
        wdata_out = 32'h0000_0000;
    end

    // Any of the four size codes, SIZE_NONE included, may be issued; the request holds through its edge
    task automatic xfer(input logic w, input logic [7:0] a, input access_size_t s,
                        input logic [31:0] d, output logic k, output logic [31:0] r);
        sel_out = 1'b1;
        write_out = w;
        addr_out = a;
        size_out = s;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        k = ack_in;
        r = rdata_in;
    endtask

    // Released address and write data show their inverse, so stale values never look valid
    task automatic idle();
        sel_out = 1'b0;
        write_out = 1'b0;
        addr_out = ~addr_out;
        size_out = SIZE_NONE;
        wdata_out = ~wdata_out;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_local_bus_fast_gpio.sv
// Self-checking bench for the fast local-bus I/O port.
// Assumes the core model drives the bus; pads and fixed pins come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_local_bus_fast_gpio;
    import fast_io_pkg::*;
    logic clk_in, nrst_in, sel, wr, ack;
    logic [7:0] addr;
    access_size_t size;
    logic [31:0] wdata, rdata, r;
    logic [15:0] pad_in, fixed, pad_out, pad_oe, pad_sel;
    int fail_count = 0;
    int comparisons = 0;

    fast_io_core_model i_core (.clk_in(clk_in), .sel_out(sel), .write_out(wr),
        .addr_out(addr), .size_out(size), .wdata_out(wdata), .rdata_in(rdata), .ack_in(ack));
    local_bus_fast_gpio i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_sel_in(sel),
        .bus_write_in(wr), .bus_addr_in(addr), .bus_size_in(size), .bus_wdata_in(wdata),
        .bus_rdata_out(rdata), .bus_ack_out(ack), .pad_in(pad_in),
        .fixed_function_in(fixed), .pad_out(pad_out), .pad_oe_out(pad_oe),
        .pad_select_out(pad_sel));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input access_size_t s,
                       input logic [31:0] d);
        logic k;
        i_core.xfer(w, a, s, d, k, r);
        check("ack", {31'h0, k}, 32'h1);
    endtask

    task automatic t_reset();
        check("pads", {pad_out, pad_oe | pad_sel}, 32'h0);
        acc(1'b0, OFS_DIR, SIZE_LONG, 32'h0);
        check("dir", r, 32'h0);
        acc(1'b0, OFS_ENABLE, SIZE_WORD, 32'h0);
        check("enable", r, 32'h0);
        i_core.idle();
        check("ack idle", {31'h0, ack}, 32'h0);
    endtask

    task automatic t_ctrl();
        acc(1'b1, OFS_DIR, SIZE_LONG, 32'h0000_00ff);
        acc(1'b1, OFS_ENABLE, SIZE_LONG, 32'h0000_0f0f);
        acc(1'b1, OFS_DATA, SIZE_LONG, 32'h0000_00a5);
        check("oe", {16'h0, pad_oe}, 32'h0000_000f);
        check("select", {16'h0, pad_sel}, 32'h0000_0f0f);
        check("pad_out", {16'h0, pad_out}, 32'h0000_00a5);
        acc(1'b0, OFS_DIR, SIZE_LONG, 32'h0);
        check("dir read", r, 32'h0000_00ff);
        i_core.idle();
    endtask

    task automatic t_alt();
        logic [7:0] ofs [3];
        logic [15:0] val [3];
        logic [15:0] exp [3];
        logic [15:0] prev;
        ofs = '{OFS_SET, OFS_CLEAR, OFS_TOGGLE};
        val = '{16'h0101, 16'h0011, 16'h8180};
        exp = '{16'h01f1, 16'h01e0, 16'h8060};
        acc(1'b1, OFS_DIR, SIZE_LONG, 32'h0000_ffff);
        acc(1'b1, OFS_DATA, SIZE_LONG, 32'h0000_00f0);
        prev = 16'h00f0;
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, ofs[i], SIZE_LONG, {16'h0, val[i]});
            check("alt store", {16'h0, pad_out}, {16'h0, exp[i]});
            acc(1'b0, ofs[i], SIZE_LONG, 32'h0);
            check("alt read", r, {16'h0, exp[i]});
            check("untouched", {16'h0, pad_out & ~val[i]}, {16'h0, prev & ~val[i]});
            prev = exp[i];
        end
        i_core.idle();
    endtask

    task automatic t_size();
        acc(1'b1, OFS_DATA, SIZE_LONG, 32'h0);
        acc(1'b1, OFS_DATA + 8'h01, SIZE_BYTE, 32'h0000_a500);
        check("byte lane1", {16'h0, pad_out}, 32'h0000_a500);
        acc(1'b1, OFS_DATA, SIZE_WORD, 32'h0000_1234);
        check("word", {16'h0, pad_out}, 32'h0000_1234);
        acc(1'b1, OFS_SET, SIZE_BYTE, 32'h0000_ff0f);
        check("byte set", {16'h0, pad_out}, 32'h0000_123f);
        acc(1'b1, OFS_DATA + 8'h02, SIZE_BYTE, 32'h00ff_0000);
        acc(1'b1, OFS_DATA, SIZE_NONE, 32'h0);
        acc(1'b0, OFS_DATA + 8'h01, SIZE_BYTE, 32'h0);
        check("byte read", r, 32'h0000_123f);
        i_core.idle();
    endtask

    task automatic t_pads();
        acc(1'b1, OFS_DIR, SIZE_LONG, 32'h0);
        pad_in = 16'h5a3c;
        repeat (4) i_core.idle();
        acc(1'b0, OFS_DATA, SIZE_LONG, 32'h0);
        check("pad read", r, 32'h0000_5a3c);
        acc(1'b1, 8'h20, SIZE_LONG, 32'h0000_ffff);
        acc(1'b0, 8'h20, SIZE_LONG, 32'h0);
        check("unmapped", r, 32'h0);
        acc(1'b0, OFS_DIR, SIZE_LONG, 32'h0);
        check("dir kept", r, 32'h0);
        i_core.idle();
    endtask

    task automatic t_fixed();
        acc(1'b1, OFS_ENABLE, SIZE_LONG, 32'h0000_ffff);
        fixed = 16'h0003;
        repeat (3) i_core.idle();
        check("fixed select", {16'h0, pad_sel}, 32'h0000_fffc);
        acc(1'b1, OFS_ENABLE, SIZE_LONG, 32'h0000_ffff);
        repeat (2) i_core.idle();
        acc(1'b0, OFS_ENABLE, SIZE_LONG, 32'h0);
        check("fixed enable", r, 32'h0000_fffc);
        fixed = 16'h0000;
        i_core.idle();
    endtask

    // Whole sequence needs under sixty cycles; allow ample margin
    initial begin
        #(5 * 4000);
        fail_count++;
        print_verdict();
    end

    initial begin
        nrst_in = 1'b0;
        pad_in = 16'h0000;
        fixed = 16'h0000;
        repeat (12) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        t_reset();
        t_ctrl();
        t_alt();
        t_size();
        t_pads();
        t_fixed();
        print_verdict();
    end
endmodule
`default_nettype wire
